// ---- logic/edc_consts.vh ----
// constants for the electrode detect and channel configuration bank
`ifndef EDC_CONSTS_VH
`define EDC_CONSTS_VH

// register indices as printed; byte address is four times the index
`define EDC_IDX_DETECT_CONTROL  8'h04
`define EDC_IDX_CHANNEL_FIRST   8'h05
`define EDC_IDX_CHANNEL_LAST    8'h0c
`define EDC_IDX_BIAS_POS        8'h0d
`define EDC_IDX_BIAS_NEG        8'h0e
`define EDC_IDX_DETECT_POS      8'h0f
`define EDC_IDX_DETECT_NEG      8'h10
`define EDC_IDX_CURRENT_DIR     8'h11
`define EDC_IDX_POS_STATUS      8'h12
`define EDC_IDX_NEG_STATUS      8'h13
`define EDC_IDX_BIAS_CTRL       8'h20

// detect_control field positions
`define EDC_THR_HI   7
`define EDC_THR_LO   5
`define EDC_RES_BIT  4
`define EDC_CUR_HI   3
`define EDC_CUR_LO   2
`define EDC_FRQ_HI   1
`define EDC_FRQ_LO   0

// channel_settings field positions
`define EDC_PWRDN_BIT 7
`define EDC_GAIN_HI  6
`define EDC_GAIN_LO  4
`define EDC_ZERO_BIT 3
`define EDC_SEL_HI   2
`define EDC_SEL_LO   0

// detection frequency codes
`define EDC_FRQ_NONE 2'h0
`define EDC_FRQ_AC   2'h1
`define EDC_FRQ_DC   2'h3

// input selector code that carries the bias drive
`define EDC_SEL_BIAS 3'h2

// reset value of every byte
`define EDC_RESET_BYTE 8'h00

// axi responses
`define EDC_RESP_OKAY   2'h0
`define EDC_RESP_SLVERR 2'h2

`endif

// ---- logic/edc_config_bank.v ----
// register bank for electrode detect control and per-channel settings
//
// Overview of operation
// - bits 7:5 of control: comparator threshold
// - bit 4 selects resistor detection mode
// - bits 3:2 set excitation current level
// - bits 1:0 select AC or DC detection
// - eight channel registers at 05h to 0Ch
// - bit 7 powers down; bits 6:4 gain
// - bits 2:0 select the channel input
// - code 010 needs bias measure enable
// - enable routes bias drive to code-010 channels
// - 0Dh mask: positive inputs into bias drive
// - 0Eh mask: negative inputs into bias drive
// - channel mask bits above channel count absent
// - 0Fh mask: positive electrode disconnect sensing
// - 10h mask: negative electrode disconnect sensing
// - 11h mask reverses excitation current direction
// - status bit reads one when disconnected
//
// byte address map, four times the register index
// 0x10       detect_control
// 0x14..0x30 channel_settings, channel one first
// 0x34       bias_drive_positive_select
// 0x38       bias_drive_negative_select
// 0x3c       electrode_detect_positive_select
// 0x40       electrode_detect_negative_select
// 0x44       detect_current_direction
// 0x48       positive_disconnect_status, read only
// 0x4c       negative_disconnect_status, read only
// 0x80       bias measure enable in bit 0
//
// timing: write answer two edges after both halves are taken,
// read data one edge after the address; field outputs lag one edge more
//
// limits: only byte lane 0 carries data, upper read bits are zero;
// a write with lane 0 strobe low stores nothing but still answers okay;
// status bytes ignore writes; unmapped addresses answer slverr
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "edc_consts.vh"

module edc_config_bank #(
	parameter NUM_CH = 8
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [7:0]   s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output reg          s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output reg          s_axi_wready,
	output reg  [1:0]   s_axi_bresp,
	output reg          s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [7:0]   s_axi_araddr,
	input  wire         s_axi_arvalid,
	output reg          s_axi_arready,
	output reg  [31:0]  s_axi_rdata,
	output reg  [1:0]   s_axi_rresp,
	output reg          s_axi_rvalid,
	input  wire         s_axi_rready,
	input  wire [7:0]   positive_off_in,
	input  wire [7:0]   negative_off_in,
	output reg  [2:0]   comparator_threshold,
	output reg          resistor_detect_select,
	output reg  [1:0]   excitation_current_level,
	output reg  [1:0]   detect_frequency_select,
	output reg  [7:0]   channel_powerdown,
	output reg  [23:0]  channel_gain,
	output reg  [23:0]  input_selector,
	output reg  [7:0]   bias_route_enable,
	output reg  [7:0]   bias_drive_positive_select,
	output reg  [7:0]   bias_drive_negative_select,
	output reg  [7:0]   electrode_detect_positive_select,
	output reg  [7:0]   electrode_detect_negative_select,
	output reg  [7:0]   detect_current_direction,
	output reg  [7:0]   positive_disconnect_status,
	output reg  [7:0]   negative_disconnect_status
);

	// ==================================================================
	// storage
	reg  [7:0]  detect_control_q;
	reg  [7:0]  channel_settings_q [0:7];
	reg  [7:0]  bias_pos_q;
	reg  [7:0]  bias_neg_q;
	reg  [7:0]  det_pos_q;
	reg  [7:0]  det_neg_q;
	reg  [7:0]  cur_dir_q;
	reg         bias_measure_enable_q;
	reg  [7:0]  pos_s1_q;
	reg  [7:0]  pos_s2_q;
	reg  [7:0]  pos_s3_q;
	reg  [7:0]  neg_s1_q;
	reg  [7:0]  neg_s2_q;
	reg  [7:0]  neg_s3_q;
	reg  [7:0]  pos_stat_q;
	reg  [7:0]  neg_stat_q;
	reg  [5:0]  aw_idx_q;
	reg         aw_held_q;
	reg  [7:0]  w_byte_q;
	reg         w_en_q;
	reg         w_held_q;
	integer     i;

	// mask of implemented channel bits for the variant in use
	wire [7:0]  ch_mask;
	assign ch_mask = (NUM_CH >= 8) ? 8'hff : ((NUM_CH >= 6) ? 8'h3f : 8'h0f);

	// ==================================================================
	// decode helpers
	// word address to register index; byte address bits 1:0 are ignored
	function [5:0] word_index;
		input [7:0] addr;
		begin
			word_index = addr[7:2];
		end
	endfunction

	// is this index a channel register slot
	function is_channel;
		input [5:0] idx;
		begin
			is_channel = ({2'h0, idx} >= `EDC_IDX_CHANNEL_FIRST) &&
				({2'h0, idx} <= `EDC_IDX_CHANNEL_LAST);
		end
	endfunction

	// channel number (0..7) from an index inside the channel range
	function [2:0] channel_of;
		input [5:0] idx;
		reg   [7:0] d;
		begin
			d = {2'h0, idx} - `EDC_IDX_CHANNEL_FIRST;
			channel_of = d[2:0];
		end
	endfunction

	// is the index mapped at all
	function is_mapped;
		input [5:0] idx;
		begin
			is_mapped = (({2'h0, idx} >= `EDC_IDX_DETECT_CONTROL) &&
				({2'h0, idx} <= `EDC_IDX_NEG_STATUS)) ||
				({2'h0, idx} == `EDC_IDX_BIAS_CTRL);
		end
	endfunction

	// ==================================================================
	// write channel: address and data taken in either order, then one response
	wire        do_write;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EDC_RESP_OKAY;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_idx_q      <= 6'h00;
			w_byte_q      <= `EDC_RESET_BYTE;
			w_en_q        <= 1'b0;
		end
		else
		begin
			// ready is offered one cycle after valid, so a pulse never doubles up
			s_axi_awready <= s_axi_awvalid && !aw_held_q && !s_axi_awready;
			s_axi_wready  <= s_axi_wvalid && !w_held_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_idx_q  <= word_index(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_en_q   <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(aw_idx_q) ? `EDC_RESP_OKAY : `EDC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==================================================================
	// register file; status registers ignore writes
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			detect_control_q      <= `EDC_RESET_BYTE;
			bias_pos_q            <= `EDC_RESET_BYTE;
			bias_neg_q            <= `EDC_RESET_BYTE;
			det_pos_q             <= `EDC_RESET_BYTE;
			det_neg_q             <= `EDC_RESET_BYTE;
			cur_dir_q             <= `EDC_RESET_BYTE;
			bias_measure_enable_q <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
				channel_settings_q[i] <= `EDC_RESET_BYTE;
		end
		else if (do_write && w_en_q)
		begin
			// full-byte writes, read back as written on implemented bits
			if ({2'h0, aw_idx_q} == `EDC_IDX_DETECT_CONTROL)
				detect_control_q <= w_byte_q;
			// all eight channel slots exist on every variant; only the masks and status bytes shrink
			if (is_channel(aw_idx_q))
				channel_settings_q[channel_of(aw_idx_q)] <= w_byte_q;
			if ({2'h0, aw_idx_q} == `EDC_IDX_BIAS_POS)
				bias_pos_q <= w_byte_q & ch_mask;
			if ({2'h0, aw_idx_q} == `EDC_IDX_BIAS_NEG)
				bias_neg_q <= w_byte_q & ch_mask;
			if ({2'h0, aw_idx_q} == `EDC_IDX_DETECT_POS)
				det_pos_q <= w_byte_q & ch_mask;
			if ({2'h0, aw_idx_q} == `EDC_IDX_DETECT_NEG)
				det_neg_q <= w_byte_q & ch_mask;
			if ({2'h0, aw_idx_q} == `EDC_IDX_CURRENT_DIR)
				cur_dir_q <= w_byte_q & ch_mask;
			if ({2'h0, aw_idx_q} == `EDC_IDX_BIAS_CTRL)
				bias_measure_enable_q <= w_byte_q[0];
		end
	end

	// ==================================================================
	// disconnect inputs come from the analog side: three stages, change on agreement
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pos_s1_q   <= `EDC_RESET_BYTE;
			pos_s2_q   <= `EDC_RESET_BYTE;
			pos_s3_q   <= `EDC_RESET_BYTE;
			neg_s1_q   <= `EDC_RESET_BYTE;
			neg_s2_q   <= `EDC_RESET_BYTE;
			neg_s3_q   <= `EDC_RESET_BYTE;
			pos_stat_q <= `EDC_RESET_BYTE;
			neg_stat_q <= `EDC_RESET_BYTE;
		end
		else
		begin
			// stage one may go metastable, so only stages two and three are compared;
			// the cost is a status that shows four edges after the pin moves
			pos_s1_q <= positive_off_in;
			pos_s2_q <= pos_s1_q;
			pos_s3_q <= pos_s2_q;
			neg_s1_q <= negative_off_in;
			neg_s2_q <= neg_s1_q;
			neg_s3_q <= neg_s2_q;
			// a bit moves only where stages two and three agree; 1 means off
			pos_stat_q <= ((pos_s2_q & pos_s3_q) | (pos_stat_q & (pos_s2_q | pos_s3_q)))
				& ch_mask;
			neg_stat_q <= ((neg_s2_q & neg_s3_q) | (neg_stat_q & (neg_s2_q | neg_s3_q)))
				& ch_mask;
		end
	end

	// ==================================================================
	// read channel: one read at a time, data one cycle after address accepted
	reg  [7:0]  rd_byte;
	reg  [5:0]  rd_idx;
	always @*
	begin
		rd_idx  = word_index(s_axi_araddr);
		rd_byte = `EDC_RESET_BYTE;
		if (is_channel(rd_idx))
			rd_byte = channel_settings_q[channel_of(rd_idx)];
		else
			case ({2'h0, rd_idx})
				`EDC_IDX_DETECT_CONTROL: rd_byte = detect_control_q;
				`EDC_IDX_BIAS_POS:       rd_byte = bias_pos_q;
				`EDC_IDX_BIAS_NEG:       rd_byte = bias_neg_q;
				`EDC_IDX_DETECT_POS:     rd_byte = det_pos_q;
				`EDC_IDX_DETECT_NEG:     rd_byte = det_neg_q;
				`EDC_IDX_CURRENT_DIR:    rd_byte = cur_dir_q;
				`EDC_IDX_POS_STATUS:     rd_byte = pos_stat_q;
				`EDC_IDX_NEG_STATUS:     rd_byte = neg_stat_q;
				`EDC_IDX_BIAS_CTRL:      rd_byte = {7'h00, bias_measure_enable_q};
				default:                 rd_byte = `EDC_RESET_BYTE;
			endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `EDC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_byte};
				s_axi_rresp  <= is_mapped(rd_idx) ? `EDC_RESP_OKAY : `EDC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==================================================================
	// decoded control outputs toward the analog front end, registered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			comparator_threshold             <= 3'h0;
			resistor_detect_select           <= 1'b0;
			excitation_current_level         <= 2'h0;
			detect_frequency_select          <= `EDC_FRQ_NONE;
			channel_powerdown                <= 8'h00;
			channel_gain                     <= 24'h00_0000;
			input_selector                   <= 24'h00_0000;
			bias_route_enable                <= 8'h00;
			bias_drive_positive_select       <= 8'h00;
			bias_drive_negative_select       <= 8'h00;
			electrode_detect_positive_select <= 8'h00;
			electrode_detect_negative_select <= 8'h00;
			detect_current_direction         <= 8'h00;
			positive_disconnect_status       <= 8'h00;
			negative_disconnect_status       <= 8'h00;
		end
		else
		begin
			comparator_threshold     <= detect_control_q[`EDC_THR_HI:`EDC_THR_LO];
			resistor_detect_select   <= detect_control_q[`EDC_RES_BIT];
			excitation_current_level <= detect_control_q[`EDC_CUR_HI:`EDC_CUR_LO];
			// code 10 is unused and passes through unchanged; 00 means idle
			detect_frequency_select  <= detect_control_q[`EDC_FRQ_HI:`EDC_FRQ_LO];
			for (i = 0; i < 8; i = i + 1)
			begin
				// bit 3 is stored as written and drives nothing; the host keeps it zero
				channel_powerdown[i]     <= channel_settings_q[i][`EDC_PWRDN_BIT];
				channel_gain[3*i +: 3]   <=
					channel_settings_q[i][`EDC_GAIN_HI:`EDC_GAIN_LO];
				input_selector[3*i +: 3] <=
					channel_settings_q[i][`EDC_SEL_HI:`EDC_SEL_LO];
				// path open unless enable is set and selector asks for bias
				bias_route_enable[i] <= bias_measure_enable_q &&
					(channel_settings_q[i][`EDC_SEL_HI:`EDC_SEL_LO] == `EDC_SEL_BIAS);
			end
			bias_drive_positive_select       <= bias_pos_q;
			bias_drive_negative_select       <= bias_neg_q;
			electrode_detect_positive_select <= det_pos_q;
			electrode_detect_negative_select <= det_neg_q;
			detect_current_direction         <= cur_dir_q;
			positive_disconnect_status       <= pos_stat_q;
			negative_disconnect_status       <= neg_stat_q;
		end
	end

endmodule // edc_config_bank
`default_nettype wire

// ---- test/edc_config_bank_props.sv ----
// concurrent checks on the configuration bank ports
`timescale 1ns/1ns
`default_nettype none
module edc_config_bank_props #(
	parameter int NUM_CH = 8
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0]  positive_off_in,
	input wire logic [2:0]  comparator_threshold,
	input wire logic        resistor_detect_select,
	input wire logic [1:0]  excitation_current_level,
	input wire logic [1:0]  detect_frequency_select,
	input wire logic [23:0] input_selector,
	input wire logic [7:0]  bias_route_enable,
	input wire logic [7:0]  bias_drive_positive_select,
	input wire logic [7:0]  positive_disconnect_status
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ========================================
	// handshake steps
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// a control write must reach the field outputs within a few edges
	property ctrl_copy;
		logic [7:0] d;
		(wr_take ##0 (s_axi_awaddr == 8'h10 && s_axi_wstrb[0], d = s_axi_wdata[7:0]))
			|-> ##[1:5] {comparator_threshold, resistor_detect_select,
			excitation_current_level, detect_frequency_select} == d;
	endproperty
	// ========================================
	// assertions
	a_wr_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rd_answer: assert property (rd_take |-> ##[1:3] s_axi_rvalid)
		else $error("read data missing");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_ctrl_copy: assert property (ctrl_copy)
		else $error("control fields wrong");
	a_bias_route: assert property (bias_route_enable[0] |-> input_selector[2:0] == 3'h2)
		else $error("bias routed without selector");
	a_mask_width: assert property ((bias_drive_positive_select >> NUM_CH) == 8'h00)
		else $error("absent mask bit set");
	// filter latency is short, so a level held for eight edges must show
	a_status_follow: assert property ($stable(positive_off_in) [*8]
		|-> positive_disconnect_status == (positive_off_in & ~(8'hff << NUM_CH)))
		else $error("status not following");
endmodule // edc_config_bank_props
bind edc_config_bank edc_config_bank_props #(.NUM_CH(NUM_CH)) u_props (.*);
`default_nettype wire

// ---- test/edc_electrode_model.sv ----
// electrode model driving disconnect levels into the bank
`timescale 1ns/1ns
`default_nettype none
module edc_electrode_model (
	input  wire logic       aclk,
	input  wire logic [7:0] pos_set,
	input  wire logic [7:0] neg_set,
	output var  logic [7:0] positive_off_in,
	output var  logic [7:0] negative_off_in
);
	// levels move just after an edge; real electrodes drop at any time
	always @(posedge aclk)
	begin
		positive_off_in <= pos_set;
		negative_off_in <= neg_set;
	end
endmodule // edc_electrode_model
`default_nettype wire

// ---- test/edc_config_bank_bench.sv ----
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "edc_consts.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
	$display("Error %0t: got %h want %h", $time, (a), (e)); end end
module edc_config_bank_bench;
	localparam int NUM_CH = 6; // six channels so absent mask bits are exercised
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 0;
	logic        s_axi_wvalid = 0;
	logic        s_axi_bready = 0;
	logic        s_axi_arvalid = 0;
	logic        s_axi_rready = 0;
	logic [7:0]  pos_set = 8'h00;
	logic [7:0]  neg_set = 8'h00;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, excitation_current_level, detect_frequency_select;
	logic [31:0] s_axi_rdata;
	logic [2:0]  comparator_threshold;
	logic        resistor_detect_select;
	logic [7:0]  positive_off_in, negative_off_in, channel_powerdown, bias_route_enable;
	logic [7:0]  bias_drive_positive_select, bias_drive_negative_select;
	logic [7:0]  electrode_detect_positive_select, electrode_detect_negative_select;
	logic [7:0]  detect_current_direction, positive_disconnect_status, negative_disconnect_status;
	logic [23:0] channel_gain, input_selector, gain_exp, sel_exp;
	logic [7:0]  pd_exp, v;
	logic [1:0]  rr;
	logic [7:0]  ctl_out;
	assign ctl_out = {comparator_threshold, resistor_detect_select,
		excitation_current_level, detect_frequency_select};
	int          failures = 0;
	int          samples_checked = 0;

	edc_config_bank #(.NUM_CH(NUM_CH)) DUT (.*);
	edc_electrode_model MDL (.aclk(aclk), .pos_set(pos_set), .neg_set(neg_set),
		.positive_off_in(positive_off_in), .negative_off_in(negative_off_in));

	// ========================================
	// clock, bus tasks and verdict
	initial
		forever #2 aclk = ~aclk;
	// bit 3 kept zero in control and channel bytes; control frequency never 00 while masks set
	function automatic logic [7:0] pat(input int i);
		pat = {i[0], i[3:1], 1'b0, i[2:0]} ^ ((i >= 13) ? 8'hc8 : 8'h00)
			^ ((i == 4) ? 8'h01 : 8'h00);
	endfunction
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		logic aw_done;
		logic w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			aw_done = aw_done | (s_axi_awready === 1'b1);
			w_done = w_done | (s_axi_wready === 1'b1);
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
	endtask
	task automatic end_of_test;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		failures++;
		end_of_test();
	end

	// ========================================
	// test sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// bytes 0x10 to 0x44 come up cleared, then each holds a distinct byte
		for (int i = 4; i <= 17; i++)
			reg_read(8'(i * 4), 32'h0, `EDC_RESP_OKAY);
		for (int i = 4; i <= 17; i++)
			bus_write(8'(i * 4), pat(i), 4'h1);
		`CHK(rr, `EDC_RESP_OKAY)
		// all eight channel bytes store on a six-channel part; masks lose bits 7:6
		for (int i = 4; i <= 17; i++)
			reg_read(8'(i * 4), {24'h0, pat(i) & ((i >= 13) ? 8'h3f : 8'hff)},
				`EDC_RESP_OKAY);
		`CHK(bias_drive_positive_select, pat(13) & 8'h3f)
		`CHK(bias_drive_negative_select, pat(14) & 8'h3f)
		`CHK(electrode_detect_positive_select, pat(15) & 8'h3f)
		`CHK(electrode_detect_negative_select, pat(16) & 8'h3f)
		`CHK(detect_current_direction, pat(17) & 8'h3f)
		for (int c = 0; c < 8; c++)
		begin
			v = pat(c + 5);
			pd_exp[c] = v[7];
			gain_exp[c * 3 +: 3] = v[6:4];
			sel_exp[c * 3 +: 3] = v[2:0];
		end
		`CHK(channel_powerdown, pd_exp)
		`CHK(channel_gain, gain_exp)
		`CHK(input_selector, sel_exp)
		// every threshold and current code, frequency only AC or DC
		for (int k = 0; k < 8; k++)
		begin
			v = {3'(k), k[0], k[1:0], k[1], 1'b1};
			bus_write(8'h10, v, 4'h1);
			repeat (3) @(posedge aclk);
			`CHK(ctl_out, v)
		end
		// channel six carries selector 010; route opens only with the enable
		`CHK(bias_route_enable, 8'h00)
		bus_write(8'h80, 8'h01, 4'h1);
		repeat (3) @(posedge aclk);
		`CHK(bias_route_enable, 8'h20)
		bus_write(8'h80, 8'h00, 4'h1);
		repeat (3) @(posedge aclk);
		`CHK(bias_route_enable, 8'h00)
		// refused and ignored accesses
		reg_read(8'hfc, 32'h0, `EDC_RESP_SLVERR);
		bus_write(8'hfc, 8'h5a, 4'h1);
		`CHK(rr, `EDC_RESP_SLVERR)
		bus_write(8'h10, 8'h00, 4'h0);
		reg_read(8'h10, {24'h0, v}, `EDC_RESP_OKAY);
		bus_write(8'h48, 8'hff, 4'h1);
		reg_read(8'h48, 32'h0, `EDC_RESP_OKAY);
		// electrodes come off, then back on; the two absent channels stay clear
		pos_set <= 8'hda;
		neg_set <= 8'h21;
		repeat (12) @(posedge aclk);
		reg_read(8'h48, 32'h1a, `EDC_RESP_OKAY);
		reg_read(8'h4c, 32'h21, `EDC_RESP_OKAY);
		`CHK(positive_disconnect_status & electrode_detect_positive_select, 8'h1a)
		`CHK(negative_disconnect_status, 8'h21)
		pos_set <= 8'h00;
		neg_set <= 8'h00;
		repeat (12) @(posedge aclk);
		`CHK({positive_disconnect_status, negative_disconnect_status}, 16'h0)
		end_of_test();
	end
endmodule // edc_config_bank_bench
`default_nettype wire
